// [design/slrx_pkg.sv]
// Shared constants and types for the serial link receive status block.
package slrx_pkg;
    // Register byte offsets on the Avalon-MM slave.
    localparam logic [4:0] OFS_CTRL = 5'h00;
    localparam logic [4:0] OFS_STATUS = 5'h04;
    localparam logic [4:0] OFS_IRQ_STATUS = 5'h08;
    localparam logic [4:0] OFS_IRQ_MASK = 5'h0C;
    localparam logic [4:0] OFS_ERR_COUNT = 5'h10;
    // Control register field positions.
    localparam int CTRL_WIDE = 0;
    localparam int CTRL_LOOP = 1;
    localparam int CTRL_EXTRA = 2;
    localparam int CTRL_RATE_LO = 3;
    localparam int CTRL_RATE_HI = 4;
    localparam int CTRL_EQ = 5;
    localparam int CTRL_BITS = 6;
    localparam logic [5:0] CTRL_RESET = 6'h00;
    // Interrupt status and mask bit positions.
    localparam int IRQ_ERROR = 0;
    localparam int IRQ_LINK_UP = 1;
    localparam int IRQ_LINK_DOWN = 2;
    localparam int IRQ_CONTROL = 3;
    localparam int IRQ_BITS = 4;
    localparam logic [3:0] IRQ_RESET = 4'h0;
    // Coded frame layout: kind field, flag bit and payload.
    localparam int FRAME_BITS = 24;
    localparam int KIND_LSB = 21;
    localparam int FLAG_POS = 20;
    localparam int WORD_BITS = 20;
    localparam int NARROW_BITS = 16;
    localparam int SYNC_STAGES = 3;
    // Frame kinds carried in the coded frame.
    typedef enum logic [2:0] {
        KIND_DATA = 3'h0,
        KIND_CONTROL = 3'h1,
        KIND_FILL0 = 3'h2,
        KIND_FILL1A = 3'h3,
        KIND_FILL1B = 3'h4
    } slrx_kind_t;
    // Divider ratio codes driven to the oscillator divider chain.
    localparam logic [3:0] DIV_FULL = 4'h1;
    localparam logic [3:0] DIV_HALF = 4'h2;
    localparam logic [3:0] DIV_QUARTER = 4'h4;
    localparam logic [3:0] DIV_EIGHTH = 4'h8;
endpackage : slrx_pkg

// [design/slrx_top.sv]
// Receive-side frame status, link ready and register logic.
//
// The implementer's own choices: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps

// How it works
// (RULE1) Link-up from the state machine is retimed on the recovered frame clock and driven out inverted as link ready.
// (RULE2) A received control frame drives the active-low control indication low.
// (RULE3) In wide mode all twenty word bits are output, otherwise sixteen and the top four are driven low.
// (RULE4) A received data frame drives the active-low data indication low.
// (RULE5) User logic captures the word on the rising edge of the recovered frame clock.
// (RULE6) User logic qualifies the data indication with link ready.
// (RULE7) Loopback select takes frames from the loopback input instead of the line input.
// (RULE8) The two rate bits select a divider ratio of one, two, four or eight.
// (RULE9) Any frame that is not a valid data, control or fill frame raises the error output.
// (RULE10) Without extra-bit mode the flag must alternate across data frames, and a repeat raises the error output.
// (RULE11) Frequency-detector-off turns the frequency detector off and the phase detector on.
// (RULE12) With no data, control or error indication the frame is a fill frame and fill type is high for both type-one fills.
// (RULE13) The flag output carries the received flag bit in both modes.
// (RULE14) All parallel outputs change together so they can be sampled on one rising edge.
// (RULE15) The state machine status inputs drive the transmitter controls, the detector control and link-up.
// (RULE16) While the state machine is in reset, link ready is off and the indications are held inactive.
module slrx_top (
    // System clock and reset.
    input wire logic CLK_SYS,
    input wire logic RST,
    // Avalon-MM register slave.
    input wire logic [4:0] ADDRESS,
    input wire logic READ,
    input wire logic WRITE,
    input wire logic [31:0] WRITEDATA,
    output logic [31:0] READDATA,
    output logic WAITREQUEST,
    output logic IRQ,
    // Link side inputs, all asynchronous to CLK_SYS.
    input wire logic RECOVERED_FRAME_CLOCK,
    input wire logic [23:0] LINE_FRAME,
    input wire logic [23:0] LOOP_FRAME,
    input wire logic SM_STATE_OUT_LO,
    input wire logic SM_STATE_OUT_HI,
    input wire logic SM_RESET_N,
    // Parallel outputs.
    output logic [19:0] RX_PARALLEL_WORD,
    output logic FLAG,
    output logic DATA_FRAME_VALID_N,
    output logic CONTROL_FRAME_VALID_N,
    output logic FILL_TYPE,
    output logic ERROR,
    output logic LINK_READY_N,
    // Analog and transmitter controls.
    output logic TX_ENABLE_DATA,
    output logic TX_FILL_SELECT,
    output logic FREQ_DETECTOR_ON,
    output logic PHASE_DETECTOR_ON,
    output logic LOOPBACK_SELECT,
    output logic EQUALIZER_ON,
    output logic [3:0] RATE_DIVIDE
);
    localparam int FB = slrx_pkg::FRAME_BITS;
    localparam int KL = slrx_pkg::KIND_LSB;

    // True for a kind code that names a valid frame.
    function automatic logic kind_ok(input logic [2:0] k);
        kind_ok = (k <= 3'(slrx_pkg::KIND_FILL1B));
    endfunction : kind_ok

    // Three-stage synchronisers for every link-side input.
    logic [FB-1:0] line_s1_q, line_s2_q, line_s3_q;
    logic [FB-1:0] loop_s1_q, loop_s2_q, loop_s3_q;
    logic [3:0] pin_s1_q, pin_s2_q, pin_s3_q;
    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            line_s1_q <= '0;
            line_s2_q <= '0;
            line_s3_q <= '0;
            loop_s1_q <= '0;
            loop_s2_q <= '0;
            loop_s3_q <= '0;
            pin_s1_q <= 4'h0;
            pin_s2_q <= 4'h0;
            pin_s3_q <= 4'h0;
        end
        else
        begin
            line_s1_q <= LINE_FRAME;
            line_s2_q <= line_s1_q;
            line_s3_q <= line_s2_q;
            loop_s1_q <= LOOP_FRAME;
            loop_s2_q <= loop_s1_q;
            loop_s3_q <= loop_s2_q;
            pin_s1_q <= {RECOVERED_FRAME_CLOCK, SM_STATE_OUT_HI,
                         SM_STATE_OUT_LO, SM_RESET_N};
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end

    // Debounced levels: a pin counts once stages two and three agree.
    logic [3:0] pin_lvl_q;
    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
            pin_lvl_q <= 4'h0;
        else
            pin_lvl_q <= (pin_s3_q & ~(pin_s2_q ^ pin_s3_q))
                       | (pin_lvl_q & (pin_s2_q ^ pin_s3_q));
    end

    logic frame_edge, sm_in_reset, link_up, fd_off;
    // A recovered clock rise is seen when both late stages read high.
    assign frame_edge = pin_s2_q[3] & pin_s3_q[3] & ~pin_lvl_q[3];
    assign sm_in_reset = ~pin_lvl_q[0];
    assign fd_off = pin_lvl_q[1];
    assign link_up = pin_lvl_q[2];

    // Control register and the pins it steers.
    logic [slrx_pkg::CTRL_BITS-1:0] ctrl_q;
    logic [1:0] rate;
    logic [FB-1:0] frame;
    logic [2:0] kind;
    logic flag_in, bad_kind;
    assign rate = ctrl_q[slrx_pkg::CTRL_RATE_HI:slrx_pkg::CTRL_RATE_LO];
    assign frame = ctrl_q[slrx_pkg::CTRL_LOOP] ? loop_s3_q
                                               : line_s3_q; // RULE7
    assign kind = frame[KL+2:KL];
    assign flag_in = frame[slrx_pkg::FLAG_POS];
    assign bad_kind = ~kind_ok(kind);

    // Static controls follow the register and the state machine pins.
    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            LOOPBACK_SELECT <= 1'b0;
            EQUALIZER_ON <= 1'b0;
            RATE_DIVIDE <= slrx_pkg::DIV_FULL;
            TX_ENABLE_DATA <= 1'b0;
            TX_FILL_SELECT <= 1'b0;
            FREQ_DETECTOR_ON <= 1'b1;
            PHASE_DETECTOR_ON <= 1'b0;
        end
        else
        begin
            LOOPBACK_SELECT <= ctrl_q[slrx_pkg::CTRL_LOOP]; // RULE7
            EQUALIZER_ON <= ctrl_q[slrx_pkg::CTRL_EQ];
            case (rate) // RULE8
                2'h0: RATE_DIVIDE <= slrx_pkg::DIV_FULL;
                2'h1: RATE_DIVIDE <= slrx_pkg::DIV_HALF;
                2'h2: RATE_DIVIDE <= slrx_pkg::DIV_QUARTER;
                default: RATE_DIVIDE <= slrx_pkg::DIV_EIGHTH;
            endcase
            TX_ENABLE_DATA <= link_up; // RULE15
            TX_FILL_SELECT <= fd_off; // RULE15
            FREQ_DETECTOR_ON <= ~fd_off; // RULE11
            PHASE_DETECTOR_ON <= fd_off; // RULE11
        end
    end

    // Parallel outputs all move on one recovered clock rise.
    logic last_flag_q, have_flag_q, alt_err;
    assign alt_err = ~ctrl_q[slrx_pkg::CTRL_EXTRA] & have_flag_q
                   & (kind == 3'(slrx_pkg::KIND_DATA))
                   & (flag_in == last_flag_q); // RULE10
    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            RX_PARALLEL_WORD <= '0;
            FLAG <= 1'b0;
            DATA_FRAME_VALID_N <= 1'b1;
            CONTROL_FRAME_VALID_N <= 1'b1;
            FILL_TYPE <= 1'b0;
            ERROR <= 1'b0;
            LINK_READY_N <= 1'b1;
            last_flag_q <= 1'b0;
            have_flag_q <= 1'b0;
        end
        else if (sm_in_reset)
        begin
            // Indications are meaningless until the state machine runs.
            DATA_FRAME_VALID_N <= 1'b1; // RULE16
            CONTROL_FRAME_VALID_N <= 1'b1; // RULE16
            ERROR <= 1'b0; // RULE16
            LINK_READY_N <= 1'b1; // RULE16
            have_flag_q <= 1'b0;
        end
        else if (frame_edge)
        begin
            RX_PARALLEL_WORD[15:0] <= frame[15:0]; // RULE14
            RX_PARALLEL_WORD[19:16] <= ctrl_q[slrx_pkg::CTRL_WIDE]
                                     ? frame[19:16] : 4'h0; // RULE3
            FLAG <= flag_in; // RULE13
            DATA_FRAME_VALID_N <= kind != 3'(slrx_pkg::KIND_DATA); // RULE4
            CONTROL_FRAME_VALID_N <=
                kind != 3'(slrx_pkg::KIND_CONTROL); // RULE2
            FILL_TYPE <= (kind == 3'(slrx_pkg::KIND_FILL1A))
                       | (kind == 3'(slrx_pkg::KIND_FILL1B)); // RULE12
            ERROR <= bad_kind | alt_err; // RULE9 RULE10
            LINK_READY_N <= ~link_up; // RULE1
            if (kind == 3'(slrx_pkg::KIND_DATA))
            begin
                last_flag_q <= flag_in;
                have_flag_q <= 1'b1;
            end
        end
    end

    // Interrupt events: error and control sampled on their frame edge, link up and down on a change of link ready.
    logic [slrx_pkg::IRQ_BITS-1:0] ev, irq_st_q, irq_mask_q;
    logic link_prev_q, acc, rd_hit;
    assign acc = (READ | WRITE) & ~WAITREQUEST;
    assign rd_hit = READ & acc & (ADDRESS == slrx_pkg::OFS_IRQ_STATUS);
    always_comb
    begin
        ev = '0;
        ev[slrx_pkg::IRQ_ERROR] = frame_edge & ~sm_in_reset
                                & (bad_kind | alt_err);
        ev[slrx_pkg::IRQ_CONTROL] = frame_edge & ~sm_in_reset
                                  & (kind == 3'(slrx_pkg::KIND_CONTROL));
        ev[slrx_pkg::IRQ_LINK_UP] = ~LINK_READY_N & ~link_prev_q;
        ev[slrx_pkg::IRQ_LINK_DOWN] = LINK_READY_N & link_prev_q;
    end

    // Sticky status: a read clears it, but a new event wins.
    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            irq_st_q <= slrx_pkg::IRQ_RESET;
            link_prev_q <= 1'b0;
            IRQ <= 1'b0;
        end
        else
        begin
            irq_st_q <= (rd_hit ? '0 : irq_st_q) | ev;
            link_prev_q <= ~LINK_READY_N;
            IRQ <= |(((rd_hit ? '0 : irq_st_q) | ev) & irq_mask_q);
        end
    end

    // Error counter, saturating, cleared by any write to it.
    logic [15:0] err_cnt_q;
    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
            err_cnt_q <= 16'h0000;
        else if (WRITE & acc & (ADDRESS == slrx_pkg::OFS_ERR_COUNT))
            err_cnt_q <= 16'h0000;
        else if (ev[slrx_pkg::IRQ_ERROR] & (err_cnt_q != 16'hFFFF))
            err_cnt_q <= err_cnt_q + 16'h0001;
    end

    // Writable registers take effect on the accepting edge only.
    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            ctrl_q <= slrx_pkg::CTRL_RESET;
            irq_mask_q <= slrx_pkg::IRQ_RESET;
        end
        else if (WRITE & acc)
        begin
            if (ADDRESS == slrx_pkg::OFS_CTRL)
                ctrl_q <= WRITEDATA[slrx_pkg::CTRL_BITS-1:0];
            if (ADDRESS == slrx_pkg::OFS_IRQ_MASK)
                irq_mask_q <= WRITEDATA[slrx_pkg::IRQ_BITS-1:0];
        end
    end

    // Bus answer one cycle after the request; waitrequest rests high.
    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            WAITREQUEST <= 1'b1;
            READDATA <= 32'h0000_0000;
        end
        else if ((READ | WRITE) & WAITREQUEST)
        begin
            WAITREQUEST <= 1'b0;
            case (ADDRESS)
                slrx_pkg::OFS_CTRL: READDATA <= {26'h0, ctrl_q};
                slrx_pkg::OFS_STATUS:
                    READDATA <= {25'h0, FLAG, kind, sm_in_reset,
                                 fd_off, ~LINK_READY_N};
                slrx_pkg::OFS_IRQ_STATUS: READDATA <= {28'h0, irq_st_q | ev};
                slrx_pkg::OFS_IRQ_MASK: READDATA <= {28'h0, irq_mask_q};
                slrx_pkg::OFS_ERR_COUNT: READDATA <= {16'h0, err_cnt_q};
                default: READDATA <= 32'h0000_0000;
            endcase
        end
        else
            WAITREQUEST <= 1'b1;
    end

    // Checks on the design's own outputs.
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);

    sm_reset_hold_a: assert property (sm_in_reset |=> LINK_READY_N // RULE16
        && DATA_FRAME_VALID_N && CONTROL_FRAME_VALID_N && !ERROR)
        else $error("indications active while state machine in reset");
    link_follow_a: assert property (frame_edge && !sm_in_reset // RULE1
        |=> LINK_READY_N == !$past(link_up))
        else $error("link ready does not follow link-up");
    ctrl_flag_a: assert property (frame_edge && !sm_in_reset // RULE2
        && kind == 3'(slrx_pkg::KIND_CONTROL) |=> !CONTROL_FRAME_VALID_N
        && DATA_FRAME_VALID_N)
        else $error("control frame not indicated");
    data_flag_a: assert property (frame_edge && !sm_in_reset // RULE4
        && kind == 3'(slrx_pkg::KIND_DATA) |=> !DATA_FRAME_VALID_N
        && RX_PARALLEL_WORD[15:0] == $past(frame[15:0]))
        else $error("data frame not indicated");
    narrow_word_a: assert property (frame_edge && !sm_in_reset // RULE3
        && !ctrl_q[slrx_pkg::CTRL_WIDE] |=> RX_PARALLEL_WORD[19:16] == 4'h0)
        else $error("upper word bits not cleared");
    bad_frame_a: assert property (frame_edge && !sm_in_reset // RULE9
        && bad_kind |=> ERROR && irq_st_q[slrx_pkg::IRQ_ERROR])
        else $error("invalid frame without error");
    flag_alt_a: assert property (frame_edge && !sm_in_reset // RULE10
        && alt_err |=> ERROR && FLAG == $past(flag_in))
        else $error("flag repeat not flagged");
    fill_kind_a: assert property (frame_edge && !sm_in_reset // RULE12
        && kind == 3'(slrx_pkg::KIND_FILL1B) |=> FILL_TYPE
        && DATA_FRAME_VALID_N && CONTROL_FRAME_VALID_N && !ERROR)
        else $error("fill type wrong");
    loop_path_a: assert property (frame_edge && !sm_in_reset // RULE7
        && ctrl_q[slrx_pkg::CTRL_LOOP]
        |=> RX_PARALLEL_WORD[15:0] == $past(loop_s3_q[15:0]))
        else $error("loopback path not taken");
    detector_a: assert property ($stable(fd_off) [*2] // RULE11
        |-> PHASE_DETECTOR_ON == fd_off && FREQ_DETECTOR_ON == !fd_off)
        else $error("detector enables wrong");
    rate_div_a: assert property ($stable(rate) [*2] // RULE8
        |-> RATE_DIVIDE == 4'(1 << rate))
        else $error("divider ratio wrong");
endmodule : slrx_top

// [sim/slrx_tx_model.sv]
// Far-end transmitter model: free-running recovered clock and coded frames.
`timescale 1ns/1ps
module slrx_tx_model (
    // Recovered frame clock, free-running since fill frames keep the link up.
    output logic link_clk,
    // Coded frames on the line path and the loopback path.
    output logic [23:0] line_frame,
    output logic [23:0] loop_frame
);
    logic use_loop;

    // Clock and idle fill at time zero.
    initial
    begin
        link_clk = 1'b0;
        use_loop = 1'b0;
        line_frame = {slrx_pkg::KIND_FILL0, 21'h000000};
        loop_frame = ~{slrx_pkg::KIND_FILL0, 21'h000000};
        forever #40 link_clk = ~link_clk;
    end

    // The unused path carries the inverse, so a wrong path choice shows.
    task automatic put(input logic [23:0] f);
        line_frame <= use_loop ? ~f : f;
        loop_frame <= use_loop ? f : ~f;
    endtask : put

    // Frames change on the falling edge so they are settled at each rise.
    task automatic send(input logic [2:0] k, input logic f,
        input logic [19:0] p, input logic lp);
        @(negedge link_clk);
        use_loop = lp;
        put({k, f, p});
        @(posedge link_clk);
        @(negedge link_clk);
        put({slrx_pkg::KIND_FILL0, 21'h000000});
    endtask : send
endmodule : slrx_tx_model

// [sim/tb_top.sv]
// Self-checking testbench for the receive status block.
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
    begin \
        checked++; \
        if ((got) !== (ex)) \
        begin \
            $display("MISMATCH %s exp %h got %h", nm, ex, got); \
            n_errors++; \
        end \
    end
module tb_top;
    logic CLK_SYS, RST, READ, WRITE, WAITREQUEST, IRQ, RFC, SM_LO, SM_HI;
    logic SM_RESET_N, FLAG, DAV_N, CAV_N, FILL_TYPE, ERROR, LINK_READY_N;
    logic TX_ED, TX_FS, FD_ON, PD_ON, LOOPBACK_SELECT, EQUALIZER_ON;
    logic [4:0] ADDRESS;
    logic [31:0] WRITEDATA, READDATA, rdata;
    logic [23:0] LINE_FRAME, LOOP_FRAME;
    logic [19:0] RX_PARALLEL_WORD;
    logic [3:0] RATE_DIVIDE;
    int n_errors;
    int checked;

    slrx_top i_dut (.CLK_SYS(CLK_SYS), .RST(RST), .ADDRESS(ADDRESS),
        .READ(READ), .WRITE(WRITE), .WRITEDATA(WRITEDATA),
        .READDATA(READDATA), .WAITREQUEST(WAITREQUEST), .IRQ(IRQ),
        .RECOVERED_FRAME_CLOCK(RFC), .LINE_FRAME(LINE_FRAME),
        .LOOP_FRAME(LOOP_FRAME), .SM_STATE_OUT_LO(SM_LO),
        .SM_STATE_OUT_HI(SM_HI), .SM_RESET_N(SM_RESET_N),
        .RX_PARALLEL_WORD(RX_PARALLEL_WORD), .FLAG(FLAG),
        .DATA_FRAME_VALID_N(DAV_N), .CONTROL_FRAME_VALID_N(CAV_N),
        .FILL_TYPE(FILL_TYPE), .ERROR(ERROR), .LINK_READY_N(LINK_READY_N),
        .TX_ENABLE_DATA(TX_ED), .TX_FILL_SELECT(TX_FS),
        .FREQ_DETECTOR_ON(FD_ON), .PHASE_DETECTOR_ON(PD_ON),
        .LOOPBACK_SELECT(LOOPBACK_SELECT), .EQUALIZER_ON(EQUALIZER_ON),
        .RATE_DIVIDE(RATE_DIVIDE));

    slrx_tx_model i_tx (.link_clk(RFC), .line_frame(LINE_FRAME),
        .loop_frame(LOOP_FRAME));

    // System clock.
    initial
    begin
        CLK_SYS = 1'b0;
        forever #5 CLK_SYS = ~CLK_SYS;
    end

    // One Avalon access; the request is held until waitrequest is low.
    task automatic bus(input logic wr, input logic [4:0] a,
        input logic [31:0] wd);
        @(posedge CLK_SYS);
        ADDRESS <= a;
        WRITEDATA <= wd;
        WRITE <= wr;
        READ <= ~wr;
        // Only the watchdog ends a wait that never sees waitrequest low.
        do
        begin
            @(posedge CLK_SYS);
        end
        while (WAITREQUEST !== 1'b0);
        rdata = READDATA;
        READ <= 1'b0;
        WRITE <= 1'b0;
    endtask : bus

    task automatic rd_chk(input logic [4:0] a, input logic [31:0] ex,
        input string nm);
        bus(1'b0, a, 32'h00000000);
        `CHK(nm, ex, rdata);
    endtask : rd_chk

    // Outputs settle on the fourth system clock rise after the link rise.
    task automatic frame(input logic [2:0] k, input logic f,
        input logic [19:0] p, input logic lp);
        i_tx.send(k, f, p, lp);
        repeat (3) @(negedge CLK_SYS);
    endtask : frame

    task automatic test_done;
        $display("Comparisons %0d, mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : test_done

    // Watchdog: the tests need roughly 4 us.
    initial
    begin
        #200000;
        n_errors++;
        test_done();
    end

    // Main sequence.
    initial
    begin
        RST = 1'b1;
        READ = 1'b0;
        WRITE = 1'b0;
        ADDRESS = 5'h00;
        WRITEDATA = 32'h00000000;
        SM_LO = 1'b0;
        SM_HI = 1'b0;
        SM_RESET_N = 1'b0;
        n_errors = 0;
        checked = 0;
        repeat (4) @(posedge CLK_SYS);
        RST <= 1'b0;
        @(negedge CLK_SYS);
        `CHK("ready_n", 1'b1, LINK_READY_N);
        `CHK("rate", slrx_pkg::DIV_FULL, RATE_DIVIDE);
        `CHK("waitreq", 1'b1, WAITREQUEST);
        rd_chk(slrx_pkg::OFS_CTRL, 32'h00000000, "ctrl");
        rd_chk(slrx_pkg::OFS_IRQ_MASK, 32'h00000000, "mask");
        rd_chk(5'h14, 32'h00000000, "unmapped");
        @(posedge CLK_SYS);
        SM_HI <= 1'b1;
        SM_LO <= 1'b1;
        frame(slrx_pkg::KIND_DATA, 1'b0, 20'h00001, 1'b0);
        `CHK("dav_n held", 1'b1, DAV_N);
        `CHK("ready_n held", 1'b1, LINK_READY_N);
        @(posedge CLK_SYS);
        SM_RESET_N <= 1'b1;
        repeat (2) frame(slrx_pkg::KIND_FILL0, 1'b0, 20'h00000, 1'b0);
        `CHK("ready_n", 1'b0, LINK_READY_N);
        `CHK("tx_ed", 1'b1, TX_ED);
        `CHK("tx_fill", 1'b1, TX_FS);
        `CHK("fd_on", 1'b0, FD_ON);
        `CHK("pd_on", 1'b1, PD_ON);
        // Live kind is idle fill, detector off, link ready.
        rd_chk(slrx_pkg::OFS_STATUS, 32'h00000013, "status");
        rd_chk(slrx_pkg::OFS_IRQ_STATUS, 32'h00000002, "irq up");
        // Narrow word, then wide word, flags alternating.
        frame(slrx_pkg::KIND_DATA, 1'b0, 20'hABCDE, 1'b0);
        `CHK("narrow", 20'h0BCDE, RX_PARALLEL_WORD);
        `CHK("dav_n", 1'b0, DAV_N);
        `CHK("err", 1'b0, ERROR);
        bus(1'b1, slrx_pkg::OFS_CTRL, 32'h00000001);
        frame(slrx_pkg::KIND_DATA, 1'b1, 20'hABCDE, 1'b0);
        `CHK("wide", 20'hABCDE, RX_PARALLEL_WORD);
        `CHK("flag", 1'b1, FLAG);
        `CHK("err alt", 1'b0, ERROR);
        frame(slrx_pkg::KIND_CONTROL, 1'b0, 20'h12345, 1'b0);
        `CHK("cav_n", 1'b0, CAV_N);
        `CHK("dav_n ctl", 1'b1, DAV_N);
        for (int k = 2; k < 5; k++)
        begin
            frame(3'(k), 1'b0, 20'h00000, 1'b0);
            `CHK("fill ind", 3'b110, {DAV_N, CAV_N, ERROR});
            `CHK("fill type", k != 2, FILL_TYPE);
        end
        for (int k = 5; k < 8; k++)
        begin
            frame(3'(k), 1'b0, 20'h00000, 1'b0);
            `CHK("bad kind", 1'b1, ERROR);
        end
        frame(slrx_pkg::KIND_DATA, 1'b0, 20'h00002, 1'b0);
        `CHK("alt ok", 1'b0, ERROR);
        frame(slrx_pkg::KIND_DATA, 1'b0, 20'h00003, 1'b0);
        `CHK("alt break", 1'b1, ERROR);
        bus(1'b1, slrx_pkg::OFS_CTRL, 32'h00000005);
        frame(slrx_pkg::KIND_DATA, 1'b0, 20'h00004, 1'b0);
        `CHK("extra err", 1'b0, ERROR);
        frame(slrx_pkg::KIND_DATA, 1'b1, 20'h00005, 1'b0);
        `CHK("extra flag", 1'b1, FLAG);
        // Loopback path against line path.
        bus(1'b1, slrx_pkg::OFS_CTRL, 32'h00000003);
        frame(slrx_pkg::KIND_DATA, 1'b0, 20'h5A5A5, 1'b1);
        `CHK("loop word", 20'h5A5A5, RX_PARALLEL_WORD);
        `CHK("loop sel", 1'b1, LOOPBACK_SELECT);
        bus(1'b1, slrx_pkg::OFS_CTRL, 32'h00000001);
        frame(slrx_pkg::KIND_DATA, 1'b1, 20'h3C3C3, 1'b0);
        `CHK("line word", 20'h3C3C3, RX_PARALLEL_WORD);
        for (int r = 0; r < 4; r++)
        begin
            bus(1'b1, slrx_pkg::OFS_CTRL, 32'h00000020 | (r << 3));
            // The pins follow the register one cycle after the write.
            repeat (2) @(negedge CLK_SYS);
            `CHK("divide", 4'h1 << r, RATE_DIVIDE);
            `CHK("eq", 1'b1, EQUALIZER_ON);
        end
        // Error interrupt: raise, read-clear, then masked.
        bus(1'b0, slrx_pkg::OFS_IRQ_STATUS, 32'h00000000);
        bus(1'b1, slrx_pkg::OFS_IRQ_MASK, 32'h00000001);
        bus(1'b1, slrx_pkg::OFS_ERR_COUNT, 32'h00000000);
        frame(3'h7, 1'b0, 20'h00000, 1'b0);
        `CHK("irq", 1'b1, IRQ);
        rd_chk(slrx_pkg::OFS_IRQ_STATUS, 32'h00000001, "irq st");
        rd_chk(slrx_pkg::OFS_ERR_COUNT, 32'h00000001, "err cnt");
        @(negedge CLK_SYS);
        `CHK("irq clr", 1'b0, IRQ);
        rd_chk(slrx_pkg::OFS_IRQ_STATUS, 32'h00000000, "irq st2");
        bus(1'b1, slrx_pkg::OFS_IRQ_MASK, 32'h00000000);
        frame(3'h6, 1'b0, 20'h00000, 1'b0);
        `CHK("irq masked", 1'b0, IRQ);
        // Link drops: ready goes away and the down event is latched.
        @(posedge CLK_SYS);
        SM_HI <= 1'b0;
        frame(slrx_pkg::KIND_FILL0, 1'b0, 20'h00000, 1'b0);
        `CHK("ready_n down", 1'b1, LINK_READY_N);
        `CHK("tx_ed down", 1'b0, TX_ED);
        rd_chk(slrx_pkg::OFS_IRQ_STATUS, 32'h00000005, "irq down");
        test_done();
    end
endmodule : tb_top
